// ==== core/ssi_top.sv ====
// device end of the serial select and scan interface
module ssi_top (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic serial_in_line_i,
	input wire logic serial_shift_clock_i,
	input wire logic data_address_qualifier_i,
	input wire logic controller_select_n_i,
	input wire logic module_select_n_i,
	input wire logic scan_advance_clock_i,
	input wire logic scanning_i,
	input wire logic output_route_option_i,
	input wire logic [ssi_pkg::SSI_ID_W-1:0] module_id_i,
	output logic serial_out_line_o,
	output logic serial_out_line_oe_n_o,
	output logic [ssi_pkg::SSI_CFG_W-1:0] config_o,
	output logic config_strobe_o,
	output logic [ssi_pkg::SSI_SRC_W-1:0] output_source_counter_o
);
	import ssi_pkg::*;

	// ****************************************
	// input synchronisers
	// ****************************************
	logic sclk_rise;
	logic scan_rise;
	logic din_s;
	logic qual_s;
	logic csel_n_s;
	logic msel_n_s;
	logic scanning_s;
	logic route_s;
	logic msel_n_prev;

	ssi_edge_sync u_sclk (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.async_i(serial_shift_clock_i),
		.level_o(),
		.rise_o(sclk_rise)
	);
	ssi_edge_sync u_scan (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.async_i(scan_advance_clock_i),
		.level_o(),
		.rise_o(scan_rise)
	);
	ssi_edge_sync u_din (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.async_i(serial_in_line_i),
		.level_o(din_s),
		.rise_o()
	);
	ssi_edge_sync u_qual (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.async_i(data_address_qualifier_i),
		.level_o(qual_s),
		.rise_o()
	);
	ssi_edge_sync u_csel (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.async_i(controller_select_n_i),
		.level_o(csel_n_s),
		.rise_o()
	);
	ssi_edge_sync u_msel (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.async_i(module_select_n_i),
		.level_o(msel_n_s),
		.rise_o()
	);
	ssi_edge_sync u_scng (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.async_i(scanning_i),
		.level_o(scanning_s),
		.rise_o()
	);
	ssi_edge_sync u_route (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.async_i(output_route_option_i),
		.level_o(route_s),
		.rise_o()
	);

	// ****************************************
	// identity value synchroniser
	// ****************************************
	// static strap, so a bitwise two-flop copy is coherent once settled
	logic [SSI_ID_W-1:0] id_meta;
	logic [SSI_ID_W-1:0] id_sync;
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			id_meta <= SSI_ID_DEFAULT;
			id_sync <= SSI_ID_DEFAULT;
		end else begin
			id_meta <= module_id_i;
			id_sync <= id_meta;
		end
	end

	// ****************************************
	// stream qualification
	// ****************************************
	// stream belongs to this module only when selected and not routed to controller
	logic mod_active;
	logic data_bit;
	logic addr_bit;
	logic deselect;
	assign mod_active = ~msel_n_s & csel_n_s;
	assign data_bit = mod_active & sclk_rise & ~qual_s;
	assign addr_bit = mod_active & sclk_rise & qual_s;
	assign deselect = msel_n_s & ~msel_n_prev;

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			msel_n_prev <= 1'h1;
		end else begin
			msel_n_prev <= msel_n_s;
		end
	end

	// ****************************************
	// configuration shifter
	// ****************************************
	logic [SSI_CFG_W-1:0] cfg_shift;
	logic wrote;
	// data bits only; address bits never touch the word
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cfg_shift <= SSI_CFG_RST;
		end else if (data_bit) begin
			cfg_shift <= {cfg_shift[SSI_CFG_W-2:0], din_s};
		end
	end

	// a pure identity read must not latch a stale word
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wrote <= 1'h0;
		end else if (data_bit) begin
			wrote <= 1'h1;
		end else if (deselect) begin
			wrote <= 1'h0;
		end
	end

	// latch on deselect; a partial word keeps the last bits shifted
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			config_o <= SSI_CFG_RST;
		end else if (deselect && wrote) begin
			config_o <= cfg_shift;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			config_strobe_o <= 1'h0;
		end else begin
			config_strobe_o <= deselect & wrote;
		end
	end

	// ****************************************
	// identity shifter
	// ****************************************
	logic [SSI_ID_W-1:0] id_shift;
	logic [5:0] id_cnt;
	// zeros fill in behind the value, so the line reads low once it is spent
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			id_shift <= '0;
		end else if (msel_n_s) begin
			id_shift <= id_sync;
		end else if (addr_bit && id_cnt != SSI_ID_BITS) begin
			id_shift <= {id_shift[SSI_ID_W-2:0], 1'h0};
		end
	end

	// counter stops at the word length instead of wrapping into a second read
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			id_cnt <= SSI_BIT_CNT_RST;
		end else if (msel_n_s) begin
			id_cnt <= SSI_BIT_CNT_RST;
		end else if (addr_bit && id_cnt != SSI_ID_BITS) begin
			id_cnt <= id_cnt + 6'h01;
		end
	end

	// ****************************************
	// return line
	// ****************************************
	// msb stands before first clock; zeros after 32 bits come from the shifted-in fill
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			serial_out_line_o <= 1'h0;
		end else begin
			serial_out_line_o <= id_shift[SSI_ID_W-1];
		end
	end

	// released unless routed at position 1 and this module owns the stream
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			serial_out_line_oe_n_o <= 1'h1;
		end else begin
			serial_out_line_oe_n_o <= ~(route_s & mod_active);
		end
	end

	// ****************************************
	// output source counter
	// ****************************************
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			output_source_counter_o <= SSI_SRC_FIRST;
		end else if (scanning_s && scan_rise) begin
			if (output_source_counter_o == SSI_SRC_LAST) begin
				output_source_counter_o <= SSI_SRC_FIRST;
			end else begin
				output_source_counter_o <= output_source_counter_o + 3'h1;
			end
		end
	end
endmodule : ssi_top

// ==== core/ssi_pkg.sv ====
// package of constants for the serial select and scan interface
// Functional notes
// - qualifier low means data, high means address
// - select low routes stream to controller
// - shift serial input bits on serial clock
// - scan clock pulse advances output source counter
// - drive return line only at route option 1
// - counter selects four channels or temperature sensor
// - counter increments on scan clock rising edge
// - serial bits captured on serial clock rising edge
// - return 32-bit identity, then zeros until deselect
package ssi_pkg;
	// ****************************************
	// widths and reset values
	// ****************************************
	localparam int SSI_CFG_W = 16;
	localparam int SSI_ID_W = 32;
	localparam int SSI_SRC_W = 3;
	localparam logic [SSI_SRC_W-1:0] SSI_SRC_FIRST = 3'h0;
	localparam logic [SSI_SRC_W-1:0] SSI_SRC_LAST = 3'h4;
	localparam logic [SSI_CFG_W-1:0] SSI_CFG_RST = 16'h0000;
	localparam logic [5:0] SSI_BIT_CNT_RST = 6'h00;
	localparam logic [5:0] SSI_ID_BITS = 6'h20;
	// value is arbitrary
	localparam logic [SSI_ID_W-1:0] SSI_ID_DEFAULT = 32'h0000_5a11;
	// output sources
	typedef enum logic [SSI_SRC_W-1:0] {
		SSI_SRC_CH0 = 3'h0,
		SSI_SRC_CH1 = 3'h1,
		SSI_SRC_CH2 = 3'h2,
		SSI_SRC_CH3 = 3'h3,
		SSI_SRC_TEMP = 3'h4
	} ssi_src_t;
endpackage : ssi_pkg

// ==== core/ssi_edge_sync.sv ====
// two-flop synchroniser with rising edge pulse
module ssi_edge_sync (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic async_i,
	output logic level_o,
	output logic rise_o
);
	logic meta;
	logic sync;
	logic prev;
	// meta is read only by sync
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta <= 1'h1;
			sync <= 1'h1;
			prev <= 1'h1;
		end else begin
			meta <= async_i;
			sync <= meta;
			prev <= sync;
		end
	end
	assign level_o = sync;
	assign rise_o = sync & ~prev;
endmodule : ssi_edge_sync

// ==== bench/ssi_board_rx.sv ====
// board model that reads the return line
module ssi_board_rx (
	input wire logic sclk_i,
	input wire logic line_i,
	input wire logic oe_n_i,
	output logic [31:0] rx_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// no pull-up on the return line; a released line shows the inverse so a stray sample cannot pass
	wire logic pin = oe_n_i ? ~line_i : line_i;
	initial rx_o = '0;
	// read before the rise, msb arrives first
	always @(negedge sclk_i) rx_o <= {rx_o[30:0], pin};
endmodule : ssi_board_rx

// ==== bench/ssi_top_sva.sv ====
// checker for the device end
module ssi_top_chk (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic controller_select_n_i,
	input wire logic scan_advance_clock_i,
	input wire logic scanning_i,
	input wire logic output_route_option_i,
	input wire logic serial_out_line_oe_n_o,
	input wire logic [ssi_pkg::SSI_CFG_W-1:0] config_o,
	input wire logic config_strobe_o,
	input wire logic [ssi_pkg::SSI_SRC_W-1:0] output_source_counter_o
);
	import ssi_pkg::*;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);
	property p_route; (!output_route_option_i)[*8] |-> serial_out_line_oe_n_o; endproperty
	a_route: assert property (p_route) else $error("return line driven with route off");
	property p_csn; (!controller_select_n_i)[*8] |-> serial_out_line_oe_n_o; endproperty
	a_csn: assert property (p_csn) else $error("return line driven toward controller");
	property p_step; $changed(output_source_counter_o) |-> output_source_counter_o ==
		(($past(output_source_counter_o) == SSI_SRC_LAST) ? SSI_SRC_FIRST : $past(output_source_counter_o) + 3'h1); endproperty
	a_step: assert property (p_step) else $error("counter moved by other than one");
	property p_range; output_source_counter_o <= SSI_SRC_LAST; endproperty
	a_range: assert property (p_range) else $error("counter beyond last source");
	property p_scan; (!scanning_i)[*8] |=> $stable(output_source_counter_o); endproperty
	a_scan: assert property (p_scan) else $error("counter moved while not scanning");
	property p_idle; (!scan_advance_clock_i)[*8] |=> $stable(output_source_counter_o); endproperty
	a_idle: assert property (p_idle) else $error("counter moved without scan edge");
	property p_cause; $changed(config_o) |-> config_strobe_o; endproperty
	a_cause: assert property (p_cause) else $error("config changed without strobe");
	property p_pulse; config_strobe_o |=> !config_strobe_o; endproperty
	a_pulse: assert property (p_pulse) else $error("strobe longer than one cycle");
	c_wrap: cover property ($past(output_source_counter_o) == SSI_SRC_LAST && output_source_counter_o == SSI_SRC_FIRST);
	c_strobe: cover property (config_strobe_o);
	c_drive: cover property (!serial_out_line_oe_n_o);
endmodule : ssi_top_chk
bind ssi_top ssi_top_chk u_chk (.ref_clk_i, .rst_b_i, .controller_select_n_i, .scan_advance_clock_i, .scanning_i,
	.output_route_option_i, .serial_out_line_oe_n_o, .config_o, .config_strobe_o, .output_source_counter_o);

// ==== bench/tb.sv ====
// self-checking bench for the device end
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; $display("MISMATCH t=%0t %h %h", $time, a, b); end end
module tb
	import ssi_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	// value is arbitrary
	localparam logic [SSI_ID_W-1:0] bench_id = 32'hc3a5_9617;
	localparam logic [SSI_CFG_W-1:0] cfg_pat = 16'h830f;
	localparam logic [SSI_CFG_W-1:0] slot_pat = 16'h090b;
	logic clk = 0, rst_b = 0, sdi = 0, sclk = 1, qual = 0, csn = 1, msn = 1, scan = 0, scn = 0, route = 0;
	logic so, oe_n, stb;
	logic [15:0] cfg;
	logic [2:0] cnt;
	logic [31:0] rx;
	logic [3:0] rows [7] = '{4'h9, 4'ha, 4'hb, 4'hc, 4'h8, 4'h0, 4'h9};
	int fails = 0, checked = 0;
	always #2.5 clk = ~clk;
	ssi_top u_dut (.ref_clk_i(clk), .rst_b_i(rst_b), .serial_in_line_i(sdi), .serial_shift_clock_i(sclk),
		.data_address_qualifier_i(qual), .controller_select_n_i(csn), .module_select_n_i(msn),
		.scan_advance_clock_i(scan), .scanning_i(scn), .output_route_option_i(route), .module_id_i(bench_id),
		.serial_out_line_o(so), .serial_out_line_oe_n_o(oe_n), .config_o(cfg), .config_strobe_o(stb),
		.output_source_counter_o(cnt));
	ssi_board_rx u_board (.sclk_i(sclk), .line_i(so), .oe_n_i(oe_n), .rx_o(rx));
	task automatic w(input int n);
		repeat (n) @(negedge clk);
	endtask : w
	// one bit per 125 ns, data set well before the rise
	task automatic sh(input logic b);
		sdi = b;
		sclk = 0;
		w(12);
		sclk = 1;
		w(13);
	endtask : sh
	task print_verdict();
		if (fails == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict
	initial begin
		w(6);
		rst_b = 1;
		`CHK(cnt, SSI_SRC_FIRST)
		`CHK(oe_n, 1'b1)
		w(4);
		foreach (rows[i]) begin
			scn = rows[i][3];
			w(8);
			scan = 1;
			w(8);
			scan = 0;
			`CHK(cnt, rows[i][2:0])
		end
		msn = 0;
		w(8);
		`CHK(oe_n, 1'b1)
		for (int i = 15; i >= 0; i--) sh(cfg_pat[i]);
		// slot number toward the controller must not reach the config word
		csn = 0;
		for (int i = 15; i >= 0; i--) sh(slot_pat[i]);
		csn = 1;
		w(4);
		msn = 1;
		// bounded wait, a lost strobe ends the run
		for (int n = 0; stb !== 1'b1; n++) begin
			if (n == 20) begin
				fails++;
				print_verdict();
			end
			@(negedge clk);
		end
		`CHK(cfg, cfg_pat)
		qual = 1;
		route = 1;
		msn = 0;
		w(8);
		`CHK(oe_n, 1'b0)
		repeat (40) sh(1'b0);
		`CHK(rx, {bench_id[23:0], 8'h00})
		msn = 1;
		w(8);
		`CHK(cfg, cfg_pat)
		msn = 0;
		w(8);
		repeat (8) sh(1'b1);
		`CHK(rx[7:0], bench_id[31:24])
		csn = 0;
		w(8);
		`CHK(oe_n, 1'b1)
		csn = 1;
		w(8);
		`CHK(oe_n, 1'b0)
		// reset mid-run while deselected, then a fresh read
		msn = 1;
		w(8);
		rst_b = 0;
		w(2);
		`CHK(cnt, SSI_SRC_FIRST)
		`CHK(oe_n, 1'b1)
		`CHK(cfg, SSI_CFG_RST)
		rst_b = 1;
		w(4);
		`CHK(cnt, SSI_SRC_FIRST)
		msn = 0;
		w(8);
		repeat (8) sh(1'b1);
		`CHK(rx[7:0], bench_id[31:24])
		print_verdict();
	end
endmodule : tb
